/* verilog/far_pkg.sv */
package far_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS = 100_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int DAY_S = 86400;
    localparam int TICKS_PER_S = 1_000_000_000 / TICK_NS;
    localparam int DAY_TICKS = DAY_S * TICKS_PER_S;

    // ------------------------------------------------------------------
    // Setting ranges
    // ------------------------------------------------------------------
    localparam logic [7:0] INTERVAL_MIN = 8'h05;
    localparam logic [7:0] INTERVAL_MAX = 8'hC8;
    localparam logic [3:0] MAX_RETRY_LIMIT = 4'hA;
    localparam logic [3:0] RETRY_CNT_SAT = 4'hF;
    localparam logic [7:0] DOUT_FUNC_RETRY = 8'h1A;

    // ------------------------------------------------------------------
    // Fault bit positions, shared by both masks
    // ------------------------------------------------------------------
    localparam logic [3:0] FB_OVERCURRENT = 4'h0;
    localparam logic [3:0] FB_OVERVOLTAGE = 4'h1;
    localparam logic [3:0] FB_UNDERVOLTAGE = 4'h2;
    localparam logic [3:0] FB_DRIVE_OVERLOAD = 4'h3;
    localparam logic [3:0] FB_HEATSINK_HOT = 4'h4;
    localparam logic [3:0] FB_DRIVE_HOT = 4'h5;
    localparam logic [3:0] FB_MOTOR_PROTECT = 4'h6;
    localparam logic [3:0] FB_MOTOR_OVERLOAD = 4'h7;
    localparam logic [3:0] FB_SPEED_MISMATCH = 4'h8;
    localparam logic [3:0] FB_OPERATION_PROTECT = 4'h9;
    localparam logic [3:0] FB_CHARGE_RESISTOR_HOT = 4'hC;
    localparam logic [3:0] FB_SAFETY_INPUT_CHATTER = 4'hD;
    localparam logic [15:0] FAULT_USED_MASK = 16'h33FF;

    // ------------------------------------------------------------------
    // Subcode qualifiers
    // ------------------------------------------------------------------
    localparam logic [7:0] SUB_BRAKE_A = 8'h08;
    localparam logic [7:0] SUB_BRAKE_B = 8'h0E;
    localparam logic [7:0] SUB_OC_OV_MAX = 8'h0A;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_COUNTED_MASK = 4'h0;
    localparam logic [3:0] REG_UNLIMITED_MASK = 4'h1;
    localparam logic [3:0] REG_MAX_RETRY = 4'h2;
    localparam logic [3:0] REG_INTERVAL = 4'h3;
    localparam logic [3:0] REG_DOUT_FUNC = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'h7;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_MASK = 16'h0000;
    localparam logic [3:0] RST_MAX_RETRY = 4'h0;
    localparam logic [7:0] RST_INTERVAL = 8'h32;
    localparam logic [7:0] RST_DOUT_FUNC = 8'h00;

    // ------------------------------------------------------------------
    // Interrupt event bits
    // ------------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_AUTO_CLEAR = 0;
    localparam int IRQ_TRIP = 1;
    localparam int IRQ_LOCKED = 2;
    localparam int IRQ_DAY_CLEAR = 3;

    typedef enum logic [1:0] {
        FAR_IDLE,
        FAR_TRIPPED,
        FAR_LOCKED
    } far_fsm_e;

endpackage

/* verilog/far_tick_gen.sv */
`timescale 1ns/1ps
module far_tick_gen
    import far_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_i, // Asynchronous reset.
    input wire logic clr_i, // Restart the period.
    output logic tick_o // One-cycle pulse per period.
);

    logic [19:0] cnt_reg;
    logic tick_reg;

    // Restarting on a fault aligns the interval to the moment of the trip.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end
        else if (clr_i)
        begin
            cnt_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end
        else if (cnt_reg == 20'(TICK_CYCLES_P - 1))
        begin
            cnt_reg <= 20'h00000;
            tick_reg <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 20'h00001;
            tick_reg <= 1'b0;
        end
    end

    assign tick_o = tick_reg;

endmodule // far_tick_gen

/* verilog/far_ctrl.sv */
// Behaviour
// [R01] The retry interval accepts 0.5 s to 20.0 s in 0.1 s steps and sets the wait before a retry.
// [R02] A clear is tried only after the full interval has passed since the fault was raised.
// [R03] A trip clears automatically only while the run command is off.
// [R04] Counted retries are allowed only while the retry count stays within the maximum.
// [R05] A clear happens only if the fault's bit is 1 in the counted or the unlimited mask.
// [R06] A manual reset clears the trip and returns the retry count to zero.
// [R07] The retry count returns to zero after 24 hours with no new fault.
// [R08] Mask bits map to faults in the fixed order; bits 10, 11, 14 and 15 are unused.
// [R09] The operation-protection fault retries only for subcode 8 or 14.
// [R10] Overcurrent and overvoltage faults retry only for subcode 10 or below.
// [R11] A fault only in the unlimited mask clears after every interval without limit.
// [R12] A fault in both masks follows the counted mask and its maximum.
// [R13] The digital output shows retry in progress when its function selection is 26.
// [R14] Automatic clearing is held off while any tuning runs.
// [R15] The maximum retry count accepts 0, which disables counted retries, or 1 to 10.
// [R16] When retries are used up the trip stays latched with no further attempts.
// [R17] Each counted clear adds one to the retry count, which saturates.
`timescale 1ns/1ps
module far_ctrl
    import far_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES,
    parameter int DAY_TICKS_P = DAY_TICKS
)
(
    input wire logic sys_clk_i, // System clock, 10 MHz.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic fault_raise_i, // One-cycle pulse: a fault trips.
    input wire logic [3:0] fault_bit_i, // Mask bit of the raised fault.
    input wire logic [7:0] fault_subcode_i, // Subcode of the raised fault.
    input wire logic run_cmd_i, // Run command pin, asynchronous.
    input wire logic manual_reset_i, // Manual reset pin, asynchronous.
    input wire logic tuning_i, // Auto or pole offset tuning active.
    input wire logic [3:0] addr_i, // Register index.
    input wire logic [31:0] wdata_i, // Write data.
    input wire logic wr_i, // Write strobe.
    input wire logic rd_i, // Read strobe.
    output logic [31:0] rdata_o, // Read data, cycle after rd_i.
    output logic tripped_o, // Trip is latched.
    output logic retry_active_o, // Waiting for an automatic clear.
    output logic retry_active_out_o, // Digital output terminal.
    output logic irq_o // Level interrupt.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] run_sync;
        logic [1:0] man_sync;
        logic man_prev;
        far_fsm_e fsm;
        logic [3:0] fault_bit;
        logic [7:0] subcode;
        logic [15:0] counted_retry_fault_mask;
        logic [15:0] unlimited_retry_fault_mask;
        logic [3:0] max_retry_count;
        logic [7:0] retry_interval;
        logic [7:0] dout_func;
        logic [7:0] wait_ticks;
        logic [19:0] quiet_ticks;
        logic [3:0] retry_cnt;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic dout;
        logic tripped;
        logic retry_active;
        logic [31:0] rdata;
    } far_state_s;

    far_state_s st_reg;
    far_state_s st_next;
    logic tick;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic fault_eligible(input logic [3:0] fbit,
                                            input logic [7:0] sub,
                                            input logic [15:0] mask);
        logic ok;
        ok = mask[fbit] & FAULT_USED_MASK[fbit]; // R08 R05
        if (fbit == FB_OPERATION_PROTECT)
        begin
            ok = ok & ((sub == SUB_BRAKE_A) | (sub == SUB_BRAKE_B)); // R09
        end
        else if ((fbit == FB_OVERCURRENT) || (fbit == FB_OVERVOLTAGE))
        begin
            ok = ok & (sub <= SUB_OC_OV_MAX); // R10
        end
        return ok;
    endfunction

    // ------------------------------------------------------------------
    // Interval divider
    // ------------------------------------------------------------------
    far_tick_gen #(
        .TICK_CYCLES_P(TICK_CYCLES_P)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .clr_i(fault_raise_i),
        .tick_o(tick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic run_on;
        logic man_edge;
        logic counted;
        logic unlimited;
        logic cnt_ok;
        logic elapsed;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        run_on = 1'b0;
        man_edge = 1'b0;
        counted = 1'b0;
        unlimited = 1'b0;
        cnt_ok = 1'b0;
        elapsed = 1'b0;
        ev = '0;
        clr = '0;
        st_next = st_reg;

        // Pins pass two flops; only the second stage feeds any logic.
        st_next.run_sync = {st_reg.run_sync[0], run_cmd_i};
        st_next.man_sync = {st_reg.man_sync[0], manual_reset_i};
        st_next.man_prev = st_reg.man_sync[1];
        run_on = st_reg.run_sync[1];
        man_edge = st_reg.man_sync[1] & ~st_reg.man_prev;

        // Register writes.
        if (wr_i)
        begin
            if (addr_i == REG_COUNTED_MASK)
            begin
                st_next.counted_retry_fault_mask = wdata_i[15:0];
            end
            else if (addr_i == REG_UNLIMITED_MASK)
            begin
                st_next.unlimited_retry_fault_mask = wdata_i[15:0];
            end
            else if (addr_i == REG_MAX_RETRY)
            begin
                // Out-of-range values are dropped so the setting stays legal.
                if (wdata_i <= 32'(MAX_RETRY_LIMIT)) // R15
                begin
                    st_next.max_retry_count = wdata_i[3:0];
                end
            end
            else if (addr_i == REG_INTERVAL)
            begin
                if ((wdata_i >= 32'(INTERVAL_MIN)) && (wdata_i <= 32'(INTERVAL_MAX))) // R01
                begin
                    st_next.retry_interval = wdata_i[7:0];
                end
            end
            else if (addr_i == REG_DOUT_FUNC)
            begin
                st_next.dout_func = wdata_i[7:0];
            end
            else if (addr_i == REG_IRQ_CLEAR)
            begin
                clr = wdata_i[IRQ_W-1:0];
            end
            else if (addr_i == REG_IRQ_ENABLE)
            begin
                st_next.irq_en = wdata_i[IRQ_W-1:0];
            end
        end

        // Quiet-time counter, restarted by every new fault.
        if (fault_raise_i)
        begin
            st_next.quiet_ticks = 20'h00000;
        end
        else if (tick && (st_reg.quiet_ticks != 20'(DAY_TICKS_P)))
        begin
            st_next.quiet_ticks = st_reg.quiet_ticks + 20'h00001;
            if (st_reg.quiet_ticks == 20'(DAY_TICKS_P - 1))
            begin
                st_next.retry_cnt = 4'h0; // R07
                ev[IRQ_DAY_CLEAR] = 1'b1;
            end
        end

        // Interval counter, saturating.
        if ((st_reg.fsm == FAR_TRIPPED) && tick && (st_reg.wait_ticks != 8'hFF))
        begin
            st_next.wait_ticks = st_reg.wait_ticks + 8'h01;
        end
        elapsed = (st_reg.wait_ticks >= st_reg.retry_interval); // R02

        counted = fault_eligible(st_reg.fault_bit, st_reg.subcode,
                                 st_reg.counted_retry_fault_mask);
        // Counted mask takes priority when both bits are set.
        unlimited = ~st_reg.counted_retry_fault_mask[st_reg.fault_bit] & // R12
            fault_eligible(st_reg.fault_bit, st_reg.subcode,
                           st_reg.unlimited_retry_fault_mask); // R11
        cnt_ok = (st_reg.max_retry_count != 4'h0) &&
            (st_reg.retry_cnt < st_reg.max_retry_count); // R04 R15

        case (st_reg.fsm)
            FAR_IDLE:
            begin
                st_next.fsm = FAR_IDLE;
            end
            FAR_TRIPPED:
            begin
                if (counted && !cnt_ok)
                begin
                    // Settings changed under a waiting trip: retries are gone.
                    st_next.fsm = FAR_LOCKED; // R16
                    ev[IRQ_LOCKED] = 1'b1;
                end
                else if (!counted && !unlimited)
                begin
                    st_next.fsm = FAR_LOCKED; // R05
                    ev[IRQ_LOCKED] = 1'b1;
                end
                else if (elapsed && !run_on && !tuning_i) // R02 R03 R14
                begin
                    st_next.fsm = FAR_IDLE;
                    ev[IRQ_AUTO_CLEAR] = 1'b1;
                    if (counted && (st_reg.retry_cnt != RETRY_CNT_SAT))
                    begin
                        st_next.retry_cnt = st_reg.retry_cnt + 4'h1; // R17
                    end
                end
            end
            FAR_LOCKED:
            begin
                st_next.fsm = FAR_LOCKED;
            end
            default:
            begin
                st_next.fsm = FAR_IDLE;
            end
        endcase

        // A new fault restarts the interval and is judged at once, unless the trip is locked.
        if (fault_raise_i && (st_reg.fsm != FAR_LOCKED))
        begin
            st_next.fault_bit = fault_bit_i;
            st_next.subcode = fault_subcode_i;
            st_next.wait_ticks = 8'h00;
            ev[IRQ_TRIP] = 1'b1;
            counted = fault_eligible(fault_bit_i, fault_subcode_i,
                                     st_reg.counted_retry_fault_mask);
            unlimited = ~st_reg.counted_retry_fault_mask[fault_bit_i] &
                fault_eligible(fault_bit_i, fault_subcode_i,
                               st_reg.unlimited_retry_fault_mask);
            ev[IRQ_AUTO_CLEAR] = 1'b0;
            if ((counted && cnt_ok) || unlimited)
            begin
                st_next.fsm = FAR_TRIPPED;
            end
            else
            begin
                st_next.fsm = FAR_LOCKED; // R16
                ev[IRQ_LOCKED] = 1'b1;
            end
        end

        // Manual reset overrides the trip state, retry count and interval, including a same-cycle fault.
        if (man_edge)
        begin
            st_next.fsm = FAR_IDLE;
            st_next.retry_cnt = 4'h0; // R06
            st_next.wait_ticks = 8'h00;
        end

        // Sticky status: an event in the clearing cycle survives.
        st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
        st_next.irq = |(st_next.irq_stat & st_next.irq_en);

        st_next.tripped = (st_next.fsm != FAR_IDLE);
        st_next.retry_active = (st_next.fsm == FAR_TRIPPED);
        st_next.dout = (st_next.dout_func == DOUT_FUNC_RETRY) &
            (st_next.fsm == FAR_TRIPPED); // R13

        // Read data, valid in the cycle after the strobe only.
        st_next.rdata = 32'h00000000;
        if (rd_i)
        begin
            if (addr_i == REG_COUNTED_MASK)
            begin
                st_next.rdata = {16'h0000, st_reg.counted_retry_fault_mask};
            end
            else if (addr_i == REG_UNLIMITED_MASK)
            begin
                st_next.rdata = {16'h0000, st_reg.unlimited_retry_fault_mask};
            end
            else if (addr_i == REG_MAX_RETRY)
            begin
                st_next.rdata = {28'h0000000, st_reg.max_retry_count};
            end
            else if (addr_i == REG_INTERVAL)
            begin
                st_next.rdata = {24'h000000, st_reg.retry_interval};
            end
            else if (addr_i == REG_DOUT_FUNC)
            begin
                st_next.rdata = {24'h000000, st_reg.dout_func};
            end
            else if (addr_i == REG_STATUS)
            begin
                st_next.rdata = {16'h0000, st_reg.subcode, st_reg.retry_cnt,
                                 st_reg.fault_bit};
                st_next.rdata[31:29] = {st_reg.fsm == FAR_LOCKED,
                                        st_reg.retry_active, st_reg.tripped};
            end
            else if (addr_i == REG_IRQ_STATUS)
            begin
                st_next.rdata = {28'h0000000, st_reg.irq_stat};
            end
            else if (addr_i == REG_IRQ_ENABLE)
            begin
                st_next.rdata = {28'h0000000, st_reg.irq_en};
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
            st_reg.fsm <= FAR_IDLE;
            st_reg.counted_retry_fault_mask <= RST_MASK;
            st_reg.unlimited_retry_fault_mask <= RST_MASK;
            st_reg.max_retry_count <= RST_MAX_RETRY;
            st_reg.retry_interval <= RST_INTERVAL;
            st_reg.dout_func <= RST_DOUT_FUNC;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign tripped_o = st_reg.tripped;
    assign retry_active_o = st_reg.retry_active;
    assign retry_active_out_o = st_reg.dout;
    assign irq_o = st_reg.irq;

endmodule // far_ctrl

/* testbench/far_fault_src.sv */
`timescale 1ns/1ps
module far_fault_src
(
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_i, // Asynchronous reset.
    input wire logic req_i, // Raise a fault.
    input wire logic [3:0] bit_i, // Fault bit to report.
    input wire logic [7:0] sub_i, // Subcode to report.
    input wire logic run_i, // Run level.
    output logic fault_raise_o, // One-cycle fault pulse.
    output logic [3:0] fault_bit_o, // Fault bit.
    output logic [7:0] fault_subcode_o, // Subcode.
    output logic run_cmd_o // Run command level.
);
    // Fields toggle outside the pulse, so late sampling cannot match by luck.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fault_raise_o <= 1'b0;
            fault_bit_o <= 4'h0;
            fault_subcode_o <= 8'h00;
            run_cmd_o <= 1'b0;
        end
        else
        begin
            fault_raise_o <= req_i;
            fault_bit_o <= req_i ? bit_i : ~fault_bit_o;
            fault_subcode_o <= req_i ? sub_i : ~fault_subcode_o;
            run_cmd_o <= run_i;
        end
    end
endmodule // far_fault_src

/* testbench/far_ctrl_checker.sv */
`timescale 1ns/1ps
module far_ctrl_checker
#(
    parameter int TICK_CYCLES_P = 4
)
(
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_i, // Asynchronous reset.
    input wire logic fault_raise_i, // Fault pulse.
    input wire logic run_cmd_i, // Run command.
    input wire logic manual_reset_i, // Manual reset pin.
    input wire logic tuning_i, // Tuning active.
    input wire logic rd_i, // Read strobe.
    input wire logic [31:0] rdata_o, // Read data.
    input wire logic tripped_o, // Trip latched.
    input wire logic retry_active_o, // Waiting for a retry.
    input wire logic retry_active_out_o, // Digital output.
    input wire logic irq_o // Interrupt.
);
    localparam int MIN_WAIT = 5 * TICK_CYCLES_P;
    localparam int MAX_WAIT = 200 * TICK_CYCLES_P + 8;
    int since_fault, since_mres, wait_cnt;
    logic quiet;
    assign quiet = since_mres >= 8;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // A clear just after a manual reset is not automatic, so timing checks skip it.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            since_fault <= MIN_WAIT;
            since_mres <= 8;
            wait_cnt <= 0;
        end
        else
        begin
            since_fault <= fault_raise_i ? 0 : since_fault + int'(since_fault < MIN_WAIT);
            since_mres <= manual_reset_i ? 0 : since_mres + int'(since_mres < 8);
            wait_cnt <= (retry_active_o && !run_cmd_i && !tuning_i && !fault_raise_i)
                ? wait_cnt + 1 : 0;
        end
    end
    trip_latch_a: assert property (fault_raise_i |=> tripped_o)
        else $error("Trip not latched.");
    early_clear_a: assert property ($fell(tripped_o) && quiet |-> since_fault >= MIN_WAIT - 2)
        else $error("Clear before the interval.");
    run_block_a: assert property ($fell(tripped_o) && quiet |-> !$past(run_cmd_i, 3))
        else $error("Clear with run on.");
    tune_block_a: assert property ($fell(tripped_o) && quiet |-> !$past(tuning_i))
        else $error("Clear during tuning.");
    dout_mirror_a: assert property (retry_active_out_o |-> retry_active_o)
        else $error("Output high with no retry.");
    retry_in_trip_a: assert property (retry_active_o |-> tripped_o)
        else $error("Retry with no trip.");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("Stray read data.");
    mr_clear_a: assert property ($rose(manual_reset_i) |-> ##[2:8] !tripped_o)
        else $error("Manual reset ignored.");
    clear_bound_a: assert property (wait_cnt <= MAX_WAIT)
        else $error("Trip not cleared in time.");
    cover property ($fell(tripped_o) && quiet);
    cover property ($rose(retry_active_out_o));
    cover property ($rose(irq_o));
endmodule // far_ctrl_checker

bind far_ctrl far_ctrl_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) far_ctrl_checker_inst (
    .sys_clk_i, .rst_i, .fault_raise_i, .run_cmd_i, .manual_reset_i, .tuning_i, .rd_i,
    .rdata_o, .tripped_o, .retry_active_o, .retry_active_out_o, .irq_o
);

/* testbench/far_ctrl_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module far_ctrl_bench;
    import far_pkg::*;
    localparam int TC = 4;
    localparam logic [3:0] CB [7] = '{FB_OPERATION_PROTECT, FB_OPERATION_PROTECT,
        FB_OPERATION_PROTECT, FB_OVERCURRENT, FB_OVERCURRENT, FB_OVERVOLTAGE, 4'hA};
    localparam logic [7:0] CS [7] = '{8'h08, 8'h0E, 8'h09, 8'h0A, 8'h0B, 8'h00, 8'h00};
    localparam logic [6:0] CE = 7'h0B;
    logic sys_clk_i = 1'b0, rst_i = 1'b1;
    logic mres = 1'b0, tune = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0, run = 1'b0;
    logic [3:0] addr = 4'h0, rbit = 4'h0;
    logic [7:0] rsub = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, v;
    logic [3:0] o, fbit;
    logic [7:0] fsub;
    logic fraise, frun, tripped, ractive, rout, irq;
    int miscompares = 0;
    int n_checks = 0;
    far_fault_src far_fault_src_inst (
        .sys_clk_i, .rst_i, .req_i(req), .bit_i(rbit), .sub_i(rsub),
        .run_i(run), .fault_raise_o(fraise), .fault_bit_o(fbit), .fault_subcode_o(fsub),
        .run_cmd_o(frun)
    );
    far_ctrl #(.TICK_CYCLES_P(TC), .DAY_TICKS_P(20)) far_ctrl_inst (
        .sys_clk_i, .rst_i, .fault_raise_i(fraise), .fault_bit_i(fbit),
        .fault_subcode_i(fsub), .run_cmd_i(frun), .manual_reset_i(mres), .tuning_i(tune),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .tripped_o(tripped), .retry_active_o(ractive), .retry_active_out_o(rout),
        .irq_o(irq)
    );
    initial forever #50 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // Outputs are sampled at the falling edge, clear of the clock edge.
    task automatic rreg(input logic [3:0] a);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(negedge sys_clk_i);
        v = rdata;
        o = {irq, rout, ractive, tripped};
        @(posedge sys_clk_i);
    endtask
    task automatic raise(input logic [3:0] b, input logic [7:0] s);
        req <= 1'b1;
        rbit <= b;
        rsub <= s;
        @(posedge sys_clk_i);
        req <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic await(input logic e, input int m);
        int k;
        k = 0;
        @(negedge sys_clk_i);
        while (tripped !== 1'b0 && k < 60)
        begin
            @(negedge sys_clk_i);
            k++;
        end
        `CHK("cleared", e, k < 60);
        if (e && m > 0)
            `CHK("interval", 1'b1, k >= m);
        @(posedge sys_clk_i);
    endtask
    task automatic mr();
        mres <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        mres <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        conclude();
    end
    initial
    begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rreg(REG_COUNTED_MASK);
        `CHK("mask reset", RST_MASK, v);
        wreg(REG_INTERVAL, 32'h4);
        rreg(REG_INTERVAL);
        `CHK("interval", RST_INTERVAL, v);
        wreg(REG_INTERVAL, 32'hC9);
        wreg(REG_INTERVAL, 32'h5);
        rreg(REG_INTERVAL);
        `CHK("interval", 32'h5, v);
        wreg(REG_MAX_RETRY, 32'hB);
        rreg(REG_MAX_RETRY);
        `CHK("max retry", RST_MAX_RETRY, v);
        wreg(REG_MAX_RETRY, 32'h2);
        wreg(REG_COUNTED_MASK, 32'h5);
        wreg(REG_UNLIMITED_MASK, 32'h614);
        wreg(REG_IRQ_ENABLE, 32'h2);
        for (int i = 0; i < 2; i++)
        begin
            raise(FB_UNDERVOLTAGE, 8'h00);
            await(1'b1, 5 * TC);
        end
        rreg(REG_STATUS);
        `CHK("count", 4'h2, v[7:4]);
        raise(FB_UNDERVOLTAGE, 8'h00);
        await(1'b0, 0);
        rreg(REG_IRQ_STATUS);
        `CHK("irq status", 3'h7, v[2:0]);
        `CHK("irq", 1'b1, o[3]);
        wreg(REG_IRQ_CLEAR, 32'hF);
        wreg(REG_IRQ_ENABLE, 32'h0);
        rreg(REG_IRQ_CLEAR);
        `CHK("irq clear", 32'h0, v);
        `CHK("irq", 1'b0, o[3]);
        mr();
        rreg(REG_STATUS);
        `CHK("count", 4'h0, v[7:4]);
        `CHK("tripped", 1'b0, o[0]);
        for (int i = 0; i < 3; i++)
        begin
            raise(FB_HEATSINK_HOT, 8'h00);
            await(1'b1, 5 * TC);
        end
        for (int i = 0; i < 7; i++)
        begin
            raise(CB[i], CS[i]);
            await(CE[i], 0);
            if (!CE[i])
                mr();
        end
        raise(FB_OVERCURRENT, 8'h00);
        await(1'b1, 5 * TC);
        rreg(REG_STATUS);
        `CHK("count", 4'h1, v[7:4]);
        wreg(REG_IRQ_CLEAR, 32'h8);
        repeat (100) @(posedge sys_clk_i);
        rreg(REG_STATUS);
        `CHK("count", 4'h0, v[7:4]);
        rreg(REG_IRQ_STATUS);
        `CHK("day flag", 1'b1, v[3]);
        run <= 1'b1;
        tune <= 1'b1;
        raise(FB_HEATSINK_HOT, 8'h00);
        await(1'b0, 0);
        rreg(REG_STATUS);
        `CHK("dout", 4'h3, o[3:0]);
        wreg(REG_DOUT_FUNC, DOUT_FUNC_RETRY);
        rreg(4'hF);
        `CHK("unmapped", 32'h0, v);
        `CHK("dout", 1'b1, o[2]);
        run <= 1'b0;
        await(1'b0, 0);
        tune <= 1'b0;
        await(1'b1, 0);
        conclude();
    end
endmodule // far_ctrl_bench
